// [pfs_pkg.sv]
package pfs_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ        = 40;
  localparam int unsigned BLANK_US       = 30;
  localparam int unsigned WDOG_SHORT_US  = 20;
  localparam int unsigned WDOG_NORMAL_US = 200;
  localparam int unsigned BLANK_CYC       = BLANK_US * CLK_MHZ;
  localparam int unsigned WDOG_SHORT_CYC  = WDOG_SHORT_US * CLK_MHZ;
  localparam int unsigned WDOG_NORMAL_CYC = WDOG_NORMAL_US * CLK_MHZ;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int unsigned TMR_W      = 14;
  localparam int unsigned RUN_W      = 16;
  localparam logic        BO_RST     = 1'b1;
  localparam logic        OT_RST     = 1'b0;
  localparam logic        TPO_RST    = 1'b0;
  localparam logic        OFF_RST    = 1'b1;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic brownout_fault;
    logic output_undervoltage_fault;
    logic latch_off;
    logic overtemp_shutdown;
    logic timing_pin_open_fault;
    logic supply_lockout;
  } pfs_fault_t;

  typedef enum logic [2:0] {
    ST_OFF   = 3'h1,
    ST_FIRST = 3'h2,
    ST_RUN   = 3'h4
  } pfs_state_t;

  function automatic logic any_fault(input pfs_fault_t f);
    any_fault = |f;
  endfunction : any_fault

endpackage : pfs_pkg

// [pfs_timer.sv]
`timescale 1ns/1ps
module pfs_timer (
  input  wire logic                      clk_in,
  input  wire logic                      resetn_in,
  input  wire logic                      clear_in,
  input  wire logic [pfs_pkg::TMR_W-1:0] limit_in,
  output logic                           done_out
);

  logic [pfs_pkg::TMR_W-1:0] count_q;

  // ==========================================================================
  // Up counter, holds at limit
  // ==========================================================================
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_q <= '0;
    end else if (clear_in) begin
      count_q <= '0;
    end else if (count_q != limit_in) begin
      count_q <= count_q + 1'b1;
    end
  end

  assign done_out = (count_q == limit_in);

endmodule : pfs_timer

// [pfs_fault_supervisor.sv]
// Contract
// - Timing current under 7 uA latches fault
// - Low timing current blanked 30 us first
// - Open-pin latch cleared only in lockout
// - Any listed fault forces OFF mode
// - OFF mode holds both gate drives low
// - OFF: hysteresis source if supply ok, else pulldown
// - OFF: control capacitor discharge held throughout
// - OFF: converter ready output driven low
// - OFF: on-time processing output grounded
// - First watchdog after recovery 20 us, not 200
// - Brown-out fault starts asserted, clamp active
// - Hysteresis source only after supply start threshold
// - Over-temperature trips drive, re-enables below 80 C
// - Over-temperature state kept until cool input with hot low, or reset, reset upper
`timescale 1ns/1ps
module pfs_fault_supervisor #(
  parameter int unsigned WDOG_NORMAL_CYC = pfs_pkg::WDOG_NORMAL_CYC
) (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic brownout_detect_in,
  input  wire logic output_undervoltage_fault_in,
  input  wire logic latch_off_in,
  input  wire logic overtemp_hot_in,
  input  wire logic overtemp_cool_in,
  input  wire logic timing_current_low_in,
  input  wire logic supply_lockout_in,
  input  wire logic phase_a_req_in,
  input  wire logic phase_b_req_in,
  input  wire logic switch_event_in,
  output logic      gate_drive_a_out,
  output logic      gate_drive_b_out,
  output logic      converter_ready_out,
  output logic      control_cap_discharge_out,
  output logic      ontime_proc_ground_out,
  output logic      brownout_hyst_source_out,
  output logic      brownout_pulldown_out,
  output logic      off_mode_out,
  output logic      brownout_fault_out,
  output logic      overtemp_shutdown_out,
  output logic      timing_pin_open_fault_out,
  output logic      watchdog_expire_out
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  localparam logic [pfs_pkg::TMR_W-1:0] BLANK_LIM   = pfs_pkg::TMR_W'(pfs_pkg::BLANK_CYC - 1);
  localparam logic [pfs_pkg::TMR_W-1:0] WD_SHORT_LIM = pfs_pkg::TMR_W'(pfs_pkg::WDOG_SHORT_CYC - 1);
  localparam logic [pfs_pkg::TMR_W-1:0] WD_NORM_LIM  = pfs_pkg::TMR_W'(WDOG_NORMAL_CYC - 1);

  pfs_pkg::pfs_state_t      state_q;
  pfs_pkg::pfs_fault_t      faults;
  logic                     brownout_fault_q;
  logic                     overtemp_q;
  logic                     tpo_q;
  logic                     off_now;
  logic                     blank_done;
  logic                     wd_done;
  logic                     wd_clear;
  logic                     tpo_set;
  logic [pfs_pkg::TMR_W-1:0] wd_limit;

  // ==========================================================================
  // Fault gathering
  // ==========================================================================
  always_comb begin
    faults.brownout_fault            = brownout_fault_q;
    faults.output_undervoltage_fault = output_undervoltage_fault_in;
    faults.latch_off                 = latch_off_in;
    faults.overtemp_shutdown         = overtemp_q;
    faults.timing_pin_open_fault     = tpo_q;
    faults.supply_lockout            = supply_lockout_in;
  end

  assign off_now = pfs_pkg::any_fault(faults);

  // ==========================================================================
  // Brown-out fault flag
  // ==========================================================================
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      brownout_fault_q <= pfs_pkg::BO_RST;
    end else if (supply_lockout_in) begin
      brownout_fault_q <= 1'b1;
    end else begin
      brownout_fault_q <= brownout_detect_in;
    end
  end

  // ==========================================================================
  // Over-temperature hysteresis
  // ==========================================================================
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      overtemp_q <= pfs_pkg::OT_RST;
    end else if (overtemp_hot_in) begin
      overtemp_q <= 1'b1;
    end else if (overtemp_cool_in) begin
      overtemp_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Timing pin open latch with blanking
  // ==========================================================================
  pfs_timer u_blank (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .clear_in  (!timing_current_low_in),
    .limit_in  (BLANK_LIM),
    .done_out  (blank_done)
  );

  assign tpo_set = timing_current_low_in && blank_done;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tpo_q <= pfs_pkg::TPO_RST;
    end else if (tpo_set) begin
      tpo_q <= 1'b1;
    end else if (supply_lockout_in) begin
      tpo_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Operating state
  // ==========================================================================
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= pfs_pkg::ST_OFF;
    end else begin
      case (state_q)
        pfs_pkg::ST_OFF: begin
          if (!off_now) begin
            state_q <= pfs_pkg::ST_FIRST;
          end
        end
        pfs_pkg::ST_FIRST: begin
          if (off_now) begin
            state_q <= pfs_pkg::ST_OFF;
          end else if (wd_done || switch_event_in) begin
            state_q <= pfs_pkg::ST_RUN;
          end
        end
        pfs_pkg::ST_RUN: begin
          if (off_now) begin
            state_q <= pfs_pkg::ST_OFF;
          end
        end
        default: begin
          state_q <= pfs_pkg::ST_OFF;
        end
      endcase
    end
  end

  // ==========================================================================
  // Watchdog
  // ==========================================================================
  assign wd_limit = (state_q == pfs_pkg::ST_FIRST) ? WD_SHORT_LIM : WD_NORM_LIM;
  assign wd_clear = (state_q == pfs_pkg::ST_OFF) || switch_event_in || wd_done || off_now;

  pfs_timer u_wdog (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .clear_in  (wd_clear),
    .limit_in  (wd_limit),
    .done_out  (wd_done)
  );

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      watchdog_expire_out <= 1'b0;
    end else begin
      watchdog_expire_out <= wd_done && !off_now && !switch_event_in && (state_q != pfs_pkg::ST_OFF);
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      off_mode_out              <= pfs_pkg::OFF_RST;
      gate_drive_a_out          <= 1'b0;
      gate_drive_b_out          <= 1'b0;
      converter_ready_out       <= 1'b0;
      control_cap_discharge_out <= 1'b1;
      ontime_proc_ground_out    <= 1'b1;
    end else begin
      off_mode_out              <= off_now;
      gate_drive_a_out          <= phase_a_req_in && !off_now;
      gate_drive_b_out          <= phase_b_req_in && !off_now;
      converter_ready_out       <= !off_now;
      control_cap_discharge_out <= off_now;
      ontime_proc_ground_out    <= off_now;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      brownout_hyst_source_out <= 1'b0;
      brownout_pulldown_out    <= 1'b1;
    end else begin
      brownout_hyst_source_out <= off_now && !supply_lockout_in;
      brownout_pulldown_out    <= supply_lockout_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      brownout_fault_out        <= pfs_pkg::BO_RST;
      overtemp_shutdown_out     <= pfs_pkg::OT_RST;
      timing_pin_open_fault_out <= pfs_pkg::TPO_RST;
    end else begin
      brownout_fault_out        <= brownout_fault_q;
      overtemp_shutdown_out     <= overtemp_q;
      timing_pin_open_fault_out <= tpo_q;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  localparam int BLANK_I  = pfs_pkg::BLANK_CYC;
  localparam int WD_FIRST = pfs_pkg::WDOG_SHORT_CYC + 2;

  logic [pfs_pkg::RUN_W-1:0] low_run_q;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      low_run_q <= '0;
    end else if (!timing_current_low_in) begin
      low_run_q <= '0;
    end else if (low_run_q != {pfs_pkg::RUN_W{1'b1}}) begin
      low_run_q <= low_run_q + 1'b1;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_hot_trip;
    overtemp_hot_in ##1 overtemp_q;
  endsequence

  sequence s_recover;
    $fell(off_mode_out) && !switch_event_in;
  endsequence

  property p_tpo_blank;
    $rose(tpo_q) |-> (low_run_q >= pfs_pkg::RUN_W'(BLANK_I));
  endproperty
  a_tpo_blank: assert property (p_tpo_blank) else $error("open pin fault before blanking");

  property p_tpo_set;
    timing_current_low_in && (low_run_q == pfs_pkg::RUN_W'(BLANK_I - 1)) |=> tpo_q;
  endproperty
  a_tpo_set: assert property (p_tpo_set) else $error("open pin fault not latched");

  property p_tpo_hold;
    tpo_q && !supply_lockout_in |=> tpo_q;
  endproperty
  a_tpo_hold: assert property (p_tpo_hold) else $error("open pin fault cleared outside lockout");

  property p_off_enter;
    off_now |=> off_mode_out && control_cap_discharge_out && !converter_ready_out;
  endproperty
  a_off_enter: assert property (p_off_enter) else $error("fault did not force off mode");

  property p_off_drive;
    off_mode_out |-> !gate_drive_a_out && !gate_drive_b_out;
  endproperty
  a_off_drive: assert property (p_off_drive) else $error("gate drive active in off mode");

  property p_off_bo;
    off_mode_out |-> (brownout_hyst_source_out != brownout_pulldown_out);
  endproperty
  a_off_bo: assert property (p_off_bo) else $error("brown-out pin handling wrong in off mode");

  property p_off_misc;
    off_mode_out |-> control_cap_discharge_out && ontime_proc_ground_out && !converter_ready_out;
  endproperty
  a_off_misc: assert property (p_off_misc) else $error("off mode outputs not forced");

  property p_first_wdog;
    s_recover |-> ##[1:WD_FIRST] (watchdog_expire_out || off_mode_out || state_q == pfs_pkg::ST_RUN);
  endproperty
  a_first_wdog: assert property (p_first_wdog) else $error("first watchdog not shortened");

  property p_bo_lockout;
    supply_lockout_in |=> brownout_fault_q ##1 brownout_fault_out;
  endproperty
  a_bo_lockout: assert property (p_bo_lockout) else $error("brown-out fault not held in lockout");

  property p_src_start;
    brownout_hyst_source_out |-> !$past(supply_lockout_in);
  endproperty
  a_src_start: assert property (p_src_start) else $error("hysteresis source before start threshold");

  property p_hot_trip;
    s_hot_trip |=> off_mode_out && !gate_drive_a_out && !gate_drive_b_out;
  endproperty
  a_hot_trip: assert property (p_hot_trip) else $error("over-temperature did not stop drive");

  property p_ot_hold;
    overtemp_q && !overtemp_cool_in |=> overtemp_q;
  endproperty
  a_ot_hold: assert property (p_ot_hold) else $error("over-temperature state lost");

endmodule : pfs_fault_supervisor

// [pfs_downstream_model.sv]
`timescale 1ns/1ps
// ============================================================================
// Downstream converter started by the ready signal
// ============================================================================
module pfs_downstream_model #(
  parameter int unsigned START_CYC = 4
) (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic enable_in,
  output logic      running_out
);
  int unsigned wait_q;

  // Starts after a delay, stops as soon as ready drops
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wait_q      <= 0;
      running_out <= 1'b0;
    end else if (!enable_in) begin
      wait_q      <= 0;
      running_out <= 1'b0;
    end else if (wait_q < START_CYC) begin
      wait_q <= wait_q + 1;
    end else begin
      running_out <= 1'b1;
    end
  end
endmodule : pfs_downstream_model

// [tb.sv]
`timescale 1ns/1ps
module tb;
  localparam int unsigned WDN = 40;
  logic clk_in    = 1'b0;
  logic resetn_in = 1'b0;
  logic bo = 1'b1, uv = 1'b0, lo = 1'b0, hot = 1'b0, cool = 1'b0;
  logic tcl = 1'b0, lock = 1'b1, ra = 1'b0, rb = 1'b0, sw = 1'b0;
  logic ga, gb, rdy, dis, gnd, hys, pd, off, bof, otf, tpf, wde, run;
  int   bad_count = 0, total_checks = 0, seed = 9, n;

  // ==========================================================================
  // Clock, design and partner
  // ==========================================================================
  always #12.5 clk_in = ~clk_in;

  pfs_fault_supervisor #(.WDOG_NORMAL_CYC(WDN)) i_pfs_fault_supervisor (
    .clk_in(clk_in), .resetn_in(resetn_in), .brownout_detect_in(bo),
    .output_undervoltage_fault_in(uv), .latch_off_in(lo), .overtemp_hot_in(hot),
    .overtemp_cool_in(cool), .timing_current_low_in(tcl), .supply_lockout_in(lock),
    .phase_a_req_in(ra), .phase_b_req_in(rb), .switch_event_in(sw),
    .gate_drive_a_out(ga), .gate_drive_b_out(gb), .converter_ready_out(rdy),
    .control_cap_discharge_out(dis), .ontime_proc_ground_out(gnd),
    .brownout_hyst_source_out(hys), .brownout_pulldown_out(pd), .off_mode_out(off),
    .brownout_fault_out(bof), .overtemp_shutdown_out(otf),
    .timing_pin_open_fault_out(tpf), .watchdog_expire_out(wde));

  pfs_downstream_model i_pfs_downstream_model (
    .clk_in(clk_in), .resetn_in(resetn_in), .enable_in(rdy), .running_out(run));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Expected {ready, discharge, ground, source, pulldown}
  function automatic logic [4:0] off_pat(input logic offm, input logic lk);
    off_pat = {~offm, offm, offm, offm & ~lk, lk};
  endfunction : off_pat

  task chk_mode(input string what, input logic offm);
    chk({what, " off"}, {15'h0000, off}, {15'h0000, offm});
    chk({what, " pins"}, {11'h000, rdy, dis, gnd, hys, pd}, {11'h000, off_pat(offm, lock)});
    if (offm) chk({what, " drives"}, {14'h0000, ga, gb}, 16'h0000);
  endtask : chk_mode

  task cyc(input int k);
    repeat (k) @(negedge clk_in);
  endtask : cyc

  task clear_all;
    {bo, uv, lo, hot, cool, tcl, lock} = 7'h04;
  endtask : clear_all

  task test_done;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  initial begin
    #(25ns * 60000);
    bad_count++;
    test_done;
  end

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    chk_mode("reset", 1'b1);
    chk("reset flags", {13'h0000, bof, otf, tpf}, 16'h0004);
    resetn_in = 1'b1;
    bo = 1'b0;
    cyc(4);
    chk_mode("lockout", 1'b1);
    chk("lockout bo", {15'h0000, bof}, 16'h0001);
    lock = 1'b0;
    bo   = 1'b1;
    cyc(4);
    chk_mode("supply up", 1'b1);
    $display("test startup done");

    clear_all;
    n = 0;
    while (off !== 1'b0 && n < 20) begin cyc(1); n++; end
    chk_mode("run", 1'b0);
    n = 0;
    do begin cyc(1); n++; end while (wde !== 1'b1 && n < 2000);
    chk("first watchdog", n[15:0], 16'(pfs_pkg::WDOG_SHORT_CYC));
    n = 0;
    do begin cyc(1); n++; end while (wde !== 1'b1 && n < 2000);
    chk("normal watchdog", n[15:0], WDN[15:0]);
    chk("partner running", {15'h0000, run}, 16'h0001);
    $display("test watchdog done");

    repeat (200) begin
      {ra, rb, sw} = 3'($random(seed));
      cyc(1);
      chk("gate follow", {14'h0000, ga, gb}, {14'h0000, ra, rb});
    end
    $display("test random gates done");

    {ra, rb} = 2'h3;
    for (int i = 0; i < 5; i++) begin
      case (i)
        0: uv = 1'b1;
        1: lo = 1'b1;
        2: lock = 1'b1;
        3: bo = 1'b1;
        default: {hot, cool} = 2'h2;
      endcase
      cyc(3);
      chk_mode("fault", 1'b1);
      chk("partner stop", {15'h0000, run}, 16'h0000);
      clear_all;
      cyc(6);
      chk_mode("cleared", 1'b0);
    end
    $display("test fault list done");

    {hot, cool} = 2'h2;
    cyc(3);
    hot = 1'b0;
    cyc(6);
    chk("hot held", {14'h0000, otf, off}, 16'h0003);
    {hot, cool} = 2'h3;
    cyc(6);
    chk("hot wins", {14'h0000, otf, off}, 16'h0003);
    hot = 1'b0;
    cyc(6);
    chk("cooled", {14'h0000, otf, off}, 16'h0000);
    $display("test overtemp done");

    tcl = 1'b1;
    cyc(pfs_pkg::BLANK_CYC - 1);
    tcl = 1'b0;
    cyc(4);
    chk("blanked", {14'h0000, tpf, off}, 16'h0000);
    tcl = 1'b1;
    cyc(pfs_pkg::BLANK_CYC);
    tcl = 1'b0;
    cyc(4);
    chk("open pin", {15'h0000, tpf}, 16'h0001);
    chk_mode("open pin", 1'b1);
    cyc(20);
    chk("open held", {14'h0000, tpf, off}, 16'h0003);
    lock = 1'b1;
    cyc(3);
    lock = 1'b0;
    cyc(6);
    chk("open cleared", {14'h0000, tpf, off}, 16'h0000);
    $display("test open pin done");

    {hot, cool} = 2'h2;
    cyc(4);
    resetn_in = 1'b0;
    cyc(2);
    resetn_in = 1'b1;
    {hot, cool} = 2'h0;
    cyc(6);
    chk("reset upper", {14'h0000, otf, off}, 16'h0000);
    $display("test second reset done");
    test_done;
  end
endmodule : tb
